//--- inc/rmep_map.svh
/*
  constants of the event pin router: mapping codes, pin count, widths.
  assumes inclusion by the router package and modules only.
*/
`ifndef RMEP_MAP_SVH
`define RMEP_MAP_SVH
`define RMEP_CODE_W        2
`define RMEP_NUM_PINS      6
`define RMEP_MAP_EVENTS    2'h0
`define RMEP_MAP_TXLOCK    2'h1
`define RMEP_MAP_CRCCAD    2'h2
`define RMEP_MAP_NONE      2'h3
`define RMEP_MAP_RESET     12'h000
`define RMEP_SYNC_STAGES   3
`endif

//--- inc/rmep_pkg.sv
/*
  types of the event pin router: raw event bundle and path select status.
  assumes rmep_map.svh is on the include path.
*/
`include "rmep_map.svh"
package rmep_pkg;
  typedef struct packed {
    logic mode_ready_event;
    logic channelActivityDetected;
    logic channelActivityFinished;
    logic hopChannelChange;
    logic receiveTimeoutEvent;
    logic receiveComplete;
    logic clockOutput;
    logic synthesizerLock;
    logic headerValidEvent;
    logic payloadCrcFailure;
    logic transmitComplete;
  } rmep_events_s;

  typedef struct packed {
    logic transmitPathSelect;
    logic receivePathSelect;
  } rmep_path_s;

  typedef enum logic [1:0] {
    RMEP_PATH_SLEEP,
    RMEP_PATH_TX,
    RMEP_PATH_RX,
    RMEP_PATH_BAD
  } rmep_path_e;
endpackage : rmep_pkg

//--- hdl/rmep_sync.sv
/*
  three stage synchroniser for one pin input; output changes when stages two and three agree.
  assumes a free running sys_clk and asynchronous active low reset.
*/
`timescale 1ns/100ps
`include "rmep_map.svh"
module rmep_sync
  import rmep_pkg::*;
(
  input  wire  logic sys_clk,
  input  wire  logic rstn,
  input  wire  logic clkEn,
  input  wire  logic pinIn,
  output logic       pinOut
);
  logic [`RMEP_SYNC_STAGES-1:0] stage_r;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      stage_r <= '0;
    else if (clkEn)
      stage_r <= {stage_r[`RMEP_SYNC_STAGES-2:0], pinIn};
  end

  // stage 0 feeds only stage 1; hold last value on disagreement
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pinOut <= 1'b0;
    else if (clkEn && (stage_r[1] == stage_r[2]))
      pinOut <= stage_r[2];
  end
endmodule : rmep_sync

//--- hdl/rmep_router.sv
/*
  event pin router of a radio module: routes internal events to six event pins
  by per-pin mapping codes, frames serial access by chip select, reports path selects.
  assumes events come from logic on sys_clk; chip select, serial clock and path
  selects come from the host pins and are synchronised here.
*/
`timescale 1ns/100ps
`include "rmep_map.svh"
module rmep_router
  import rmep_pkg::*;
(
  input  wire  logic                          sys_clk,
  input  wire  logic                          rstn,
  input  wire  logic                          clkEn,
  input  wire  rmep_events_s                  events,
  input  wire  logic [`RMEP_NUM_PINS*2-1:0]   eventPinMappingCode,
  input  wire  logic                          chipSelectN,
  input  wire  logic                          serialClk,
  input  wire  logic                          transmitPathSelect,
  input  wire  logic                          receivePathSelect,
  output logic [`RMEP_NUM_PINS-1:0]           eventPin,
  output logic [`RMEP_NUM_PINS-1:0]           eventPinOeN,
  output rmep_events_s                        eventSource,
  output logic                                frameActive,
  output logic                                frameStart,
  output logic                                frameEnd,
  output logic                                serialClkRise,
  output rmep_path_e                          pathState
);
  logic csSync;
  logic sckSync;
  logic txSync;
  logic rxSync;
  logic csSync_r;
  logic sckSync_r;
  logic [`RMEP_NUM_PINS*2-1:0] code_r;
  logic [`RMEP_NUM_PINS-1:0]   route_nxt;
  logic [`RMEP_NUM_PINS-1:0]   setRx;
  logic [`RMEP_NUM_PINS-1:0]   setTx;
  logic [`RMEP_NUM_PINS-1:0]   setCad;

  rmep_sync uCs  (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
                  .pinIn(~chipSelectN), .pinOut(csSync));
  rmep_sync uSck (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
                  .pinIn(serialClk), .pinOut(sckSync));
  rmep_sync uTx  (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
                  .pinIn(transmitPathSelect), .pinOut(txSync));
  rmep_sync uRx  (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
                  .pinIn(receivePathSelect), .pinOut(rxSync));

  // mapping is registered so a code change cannot glitch a pin mid-cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      code_r <= `RMEP_MAP_RESET;
    else if (clkEn)
      code_r <= eventPinMappingCode;
  end

  // fixed event sets, pin 5 in the top bit; clock and lock share pins 5 and 4
  assign setRx  = {events.mode_ready_event, events.channelActivityDetected,
                   events.channelActivityFinished, events.hopChannelChange,
                   events.receiveTimeoutEvent, events.receiveComplete};
  assign setTx  = {events.clockOutput, events.synthesizerLock, events.headerValidEvent,
                   events.hopChannelChange, events.hopChannelChange,
                   events.transmitComplete};
  assign setCad = {events.clockOutput, events.synthesizerLock, events.payloadCrcFailure,
                   events.hopChannelChange, events.channelActivityDetected,
                   events.channelActivityFinished};

  // each pin decodes only its own code field, so one code never disturbs another pin
  for (genvar p = 0; p < `RMEP_NUM_PINS; p++)
  begin : g_pin
    always_comb
    begin
      case (code_r[`RMEP_CODE_W*p +: `RMEP_CODE_W])
        `RMEP_MAP_EVENTS: route_nxt[p] = setRx[p];
        `RMEP_MAP_TXLOCK: route_nxt[p] = setTx[p];
        `RMEP_MAP_CRCCAD: route_nxt[p] = setCad[p];
        default:          route_nxt[p] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eventPin    <= '0;
      eventPinOeN <= '1;
    end
    else if (clkEn)
    begin
      eventPin    <= route_nxt;
      eventPinOeN <= '0;
    end
  end

  // raw sources stay visible so the host can tell which event fired
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      eventSource <= '0;
    else if (clkEn)
      eventSource <= events;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      csSync_r  <= 1'b0;
      sckSync_r <= 1'b0;
    end
    else if (clkEn)
    begin
      csSync_r  <= csSync;
      sckSync_r <= sckSync;
    end
  end

  // serial clock edges only count inside a frame
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameActive   <= 1'b0;
      frameStart    <= 1'b0;
      frameEnd      <= 1'b0;
      serialClkRise <= 1'b0;
    end
    else if (clkEn)
    begin
      frameActive   <= csSync;
      frameStart    <= csSync & ~csSync_r;
      frameEnd      <= ~csSync & csSync_r;
      serialClkRise <= csSync & sckSync & ~sckSync_r;
    end
  end

  // both high is flagged rather than trusted; host owns the switch
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pathState <= RMEP_PATH_SLEEP;
    else if (clkEn)
    begin
      case ({txSync, rxSync})
        2'h2:    pathState <= RMEP_PATH_TX;
        2'h1:    pathState <= RMEP_PATH_RX;
        2'h0:    pathState <= RMEP_PATH_SLEEP;
        default: pathState <= RMEP_PATH_BAD;
      endcase
    end
  end
endmodule : rmep_router

//--- dv/rmep_router_monitor.sv
/* port checker of the event router.
   assumes a bind onto rmep_router. */
`timescale 1ns/100ps
module rmep_router_monitor
  import rmep_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rstn,
  input wire logic         clkEn,
  input wire rmep_events_s events,
  input wire logic [11:0]  eventPinMappingCode,
  input wire logic [5:0]   eventPin,
  input wire logic [5:0]   eventPinOeN,
  input wire rmep_events_s eventSource,
  input wire logic         frameActive,
  input wire logic         frameStart,
  input wire logic         frameEnd,
  input wire logic         serialClkRise
);
  logic [11:0] codeQ_r;
  logic        held;
  logic [1:0]  c0;
  // pin 0 only; the bench sweeps every pin
  assign held = clkEn && codeQ_r == eventPinMappingCode;
  assign c0 = eventPinMappingCode[1:0];
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      codeQ_r <= 12'h000;
    else
      codeQ_r <= eventPinMappingCode;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  start_ok_a: assert property (frameStart |-> frameActive && !$past(frameActive))
    else $error("bad start");
  end_pulse_a: assert property (frameEnd && clkEn |-> !frameActive ##1 !frameEnd)
    else $error("bad end");
  rise_inside_a: assert property (serialClkRise |-> frameActive || frameEnd)
    else $error("clock outside frame");
  src_copy_a: assert property (clkEn |=> eventSource == $past(events))
    else $error("stale source");
  pin_drive_a: assert property (clkEn |=> eventPinOeN == 6'h00)
    else $error("pins idle");
  map_zero_a: assert property ((held && c0 == 2'h0)[*3] |-> eventPin[0] == $past(events.receiveComplete))
    else $error("code 0 wrong");
  map_one_a: assert property ((held && c0 == 2'h1)[*3] |-> eventPin[0] == $past(events.transmitComplete))
    else $error("code 1 wrong");
  map_off_a: assert property ((held && c0 == 2'h3)[*3] |-> !eventPin[0])
    else $error("code 3 wrong");
endmodule : rmep_router_monitor
bind rmep_router rmep_router_monitor u_mon (.sys_clk, .rstn, .clkEn, .events, .eventPinMappingCode,
  .eventPin, .eventPinOeN, .eventSource, .frameActive, .frameStart, .frameEnd, .serialClkRise);

//--- dv/rmep_host_model.sv
/* host model: select, serial clock and path selects.
   assumes calls at a falling sys_clk edge. */
`timescale 1ns/100ps
module rmep_host_model
  import rmep_pkg::*;
(
  output logic chipSelectN,
  output logic serialClk,
  output logic transmitPathSelect,
  output logic receivePathSelect
);
  initial
  begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    setPath(RMEP_PATH_SLEEP);
  end
  // sel low sends clocks with no select, to see them ignored
  task automatic frame(input int n, input logic sel);
    chipSelectN = !sel;
    #48;
    repeat (n)
    begin
      serialClk = 1'b1;
      #24 serialClk = 1'b0;
      #24;
    end
    chipSelectN = 1'b1;
    #48;
  endtask : frame
  task automatic setPath(input rmep_path_e m);
    transmitPathSelect = m[0];
    receivePathSelect = m[1];
  endtask : setPath
endmodule : rmep_host_model

//--- dv/tb_top.sv
/* bench of the event router: random events and codes, frames, paths.
   assumes the host model and the checker compile beside it. */
`timescale 1ns/100ps
module tb_top
  import rmep_pkg::*;
;
  logic         sys_clk, rstn, clkEn, chipSelectN, serialClk, transmitPathSelect;
  logic         receivePathSelect, frameActive, frameStart, frameEnd, serialClkRise;
  logic [11:0]  eventPinMappingCode;
  logic [5:0]   eventPin, eventPinOeN;
  rmep_events_s events, eventSource, evHeld;
  rmep_path_e   pathState;
  int           seed = 70, checks_done = 0, miscompares = 0, rises = 0, open = 0, k, t;
  rmep_router i_rmep_router (.sys_clk, .rstn, .clkEn, .events, .eventPinMappingCode,
    .chipSelectN, .serialClk, .transmitPathSelect, .receivePathSelect, .eventPin,
    .eventPinOeN, .eventSource, .frameActive, .frameStart, .frameEnd, .serialClkRise,
    .pathState);
  rmep_host_model u_host (.chipSelectN, .serialClk, .transmitPathSelect, .receivePathSelect);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    rises <= rises + serialClkRise;
    open <= open + frameStart - frameEnd;
  end
  function automatic logic [5:0] expPins(input logic [11:0] c, input rmep_events_s e);
    logic [2:0][5:0] s;
    logic [5:0]      p;
    s[0] = {e.mode_ready_event, e.channelActivityDetected, e.channelActivityFinished,
            e.hopChannelChange, e.receiveTimeoutEvent, e.receiveComplete};
    s[1] = {e.clockOutput, e.synthesizerLock, e.headerValidEvent, e.hopChannelChange,
            e.hopChannelChange, e.transmitComplete};
    s[2] = {e.clockOutput, e.synthesizerLock, e.payloadCrcFailure, e.hopChannelChange,
            e.channelActivityDetected, e.channelActivityFinished};
    for (int i = 0; i < 6; i++)
      p[i] = (c[2*i+:2] == 2'h3) ? 1'b0 : s[c[2*i+:2]][i];
    return p;
  endfunction : expPins
  task automatic check(input string what, input logic [15:0] seen, want);
    checks_done++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clkEn = 1'b1;
    events = '0;
    eventPinMappingCode = 12'h000;
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("oe", eventPinOeN, 6'h3F);
    check("path", pathState, RMEP_PATH_SLEEP);
    rstn = 1'b1;
    // first four passes put one code on all pins
    for (int n = 0; n < 40; n++)
    begin
      events = 11'($random(seed));
      eventPinMappingCode = (n < 4) ? {6{2'(n)}} : 12'($random(seed));
      repeat (4) @(negedge sys_clk);
      check("pins", eventPin, expPins(eventPinMappingCode, events));
      check("source", eventSource, events);
    end
    // enable low must freeze pins and sources
    evHeld = events;
    clkEn = 1'b0;
    events = ~evHeld;
    repeat (4) @(negedge sys_clk);
    check("frozen src", eventSource, evHeld);
    check("frozen pins", eventPin, expPins(eventPinMappingCode, evHeld));
    clkEn = 1'b1;
    // reset in mid-run clears pins and sources; checked after one rising clock edge
    rstn = 1'b0;
    @(negedge sys_clk);
    check("reset pins", eventPin, 6'h00);
    check("reset oe", eventPinOeN, 6'h3F);
    check("reset src", eventSource, 11'h000);
    rstn = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      u_host.setPath(rmep_path_e'(m));
      repeat (10) @(negedge sys_clk);
      check("path", pathState, rmep_path_e'(m));
    end
    for (int f = 0; f < 5; f++)
    begin
      k = 1 + ($random(seed) & 7);
      t = rises;
      @(negedge sys_clk);
      u_host.frame(k, f != 4);
      for (int w = 0; w < 20 && frameActive !== 1'b0; w++)
        @(negedge sys_clk);
      check("settle", frameActive, 1'b0);
      check("rises", rises - t, (f != 4) ? k : 0);
      check("open", open, 0);
    end
    tally_and_finish();
  end
endmodule : tb_top
